// *** design/acrb_pkg.sv ***
package acrb_pkg;
   localparam int NREG = 15;
   localparam int IDX_CTRL = 0;
   localparam int IDX_SWING = 1;
   localparam int IDX_PERF1 = 2;
   localparam int IDX_GAIN = 3;
   localparam int IDX_DRIVE = 4;
   localparam int IDX_FORMAT = 5;
   localparam int IDX_UPAT_HI = 6;
   localparam int IDX_UPAT_LO = 7;
   localparam int IDX_IFCLK = 8;
   localparam int IDX_LATENCY = 9;
   localparam int IDX_PDN = 10;
   localparam int IDX_PERF2 = 11;
   localparam int IDX_PEDESTAL = 12;
   localparam int IDX_OFSLOOP = 13;
   localparam int IDX_LOWRATE = 14;
   // serial register addresses, same order as the indices above
   localparam logic [7:0] REG_ADDR [NREG] = '{
      8'h00, 8'h01, 8'h03, 8'h25, 8'h26, 8'h3D, 8'h3F, 8'h40,
      8'h41, 8'h42, 8'h43, 8'h4A, 8'hBF, 8'hCF, 8'hDF};
   // implemented bits; reserved bits are not stored and read as zero
   localparam logic [7:0] REG_MASK [NREG] = '{
      8'h01, 8'hFC, 8'h03, 8'hFF, 8'h03, 8'hE0, 8'hFF, 8'hFC,
      8'hFF, 8'hCC, 8'h53, 8'h01, 8'hFC, 8'hBC, 8'h30};
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CTRL_READOUT_BIT = 0;
   localparam int CTRL_SOFT_RESET_BIT = 1;
   localparam int DRIVE_DATA_BIT = 0;
   localparam int DRIVE_CLK_BIT = 1;
   localparam int GAIN_BYPASS_BIT = 3;
   localparam int LATENCY_MODE_BIT = 3;
   localparam logic [1:0] SWING_EN_ALL = 2'h3;
   localparam logic [7:0] READBACK_BLOCKED_ADDR = 8'h00;
   localparam logic [3:0] SERIAL_LAST_BIT = 4'hF;
   localparam logic [3:0] SERIAL_ADDR_LAST_BIT = 4'h7;
   localparam int RAMP_FULL_W = 14;
   localparam logic [1:0] RAMP_SLOW_DIV_LAST = 2'h3;
   localparam logic [2:0] SER_SYNC_INIT = 3'h4;

   typedef enum logic [2:0] {
      PAT_NORMAL = 3'b000,
      PAT_ZEROS  = 3'b001,
      PAT_ONES   = 3'b010,
      PAT_TOGGLE = 3'b011,
      PAT_RAMP   = 3'b100,
      PAT_CUSTOM = 3'b101,
      PAT_UNUSED6 = 3'b110,
      PAT_UNUSED7 = 3'b111
   } acrb_pattern_t;
endpackage

// *** design/acrb_regbank.sv ***
`timescale 1ns/1ps
// Contract
// (R1) Writing one to soft reset bit clears all registers; bit reads back zero.
// (R2) Readout bit set makes shared pin shift register contents out.
// (R3) Readout bit clear: shared pin is over-range indicator, nothing shifted.
// (R4) Six-bit swing field selects default, larger or smaller output swing.
// (R5) Swing code applies only while both swing enable bits are set.
// (R6) Controller writes 11 to performance field, never 01 or 10.
// (R7) Four-bit gain field sets gain in half-dB steps, 0 to 6 dB.
// (R8) Gain applies only with bypass bit clear and low-latency mode off.
// (R9) Pattern 000 normal, 001 all zeros, 010 all ones; 110, 111 unused.
// (R10) Pattern 011 alternates 0101 word and its complement each sample.
// (R11) Pattern 100 on 14-bit output ramps by one every sample.
// (R12) On 12-bit output the ramp steps once every fourth sample.
// (R13) Pattern 101 outputs constant user word from the two pattern registers.
// (R14) Drive register bit 1 doubles output clock driver strength.
// (R15) Drive register bit 0 doubles strength of all data drivers.
// (R16) Controller writes zero to all reserved bit positions.
// (R17) Every register holds 00h after reset.
// (R18) One write updates all fields of a register at once.
// (R19) Controller enables both performance tuning settings for best performance.
// (R20) Data sampled on falling serial clock while select low; commit every 16th.
// (R21) Serial word is 8-bit address then 8-bit data, MSB first.
// (R22) In readout mode only register 00h is writable; 00h reads back zero.
// (R23) Unmapped addresses ignore writes and read back zero.
// (R24) Serial-port configuration is safely synchronised before use in the data path.
module acrb_regbank
   import acrb_pkg::*;
#(
   parameter int DATA_W = 14
) (
   input  wire logic              REF_CLK_I,
   input  wire logic              SRST_I,
   input  wire logic              SERIAL_SELECT_N_I,
   input  wire logic              SERIAL_CLK_I,
   input  wire logic              SERIAL_PORT_INPUT_I,
   input  wire logic              OVERRANGE_I,
   input  wire logic [DATA_W-1:0] SAMPLE_I,
   output logic                   OVERRANGE_OR_READBACK_PIN_O,
   output logic      [DATA_W-1:0] DATA_O,
   output logic      [5:0]        SWING_CODE_O,
   output logic      [3:0]        GAIN_CODE_O,
   output logic                   CLOCK_DRIVER_DOUBLE_STRENGTH_O,
   output logic                   DATA_DRIVER_DOUBLE_STRENGTH_O,
   output logic      [1:0]        PERFORMANCE_TUNE_ONE_O,
   output logic                   PERFORMANCE_TUNE_TWO_O
);
   localparam logic [DATA_W-1:0] ALT_WORD = {(DATA_W/2){2'b01}};
   localparam logic [DATA_W-1:0] RAMP_MAX = '1;

   logic [7:0]        reg_q [NREG];
   logic [2:0]        ser_s;
   logic              sclk_d;
   logic [3:0]        bit_cnt;
   logic [15:0]       shift;
   logic [7:0]        rd_sr;
   logic              rd_active;
   logic              tgl;
   logic [DATA_W-1:0] ramp;
   logic [1:0]        ramp_div;

   // pins come from a free-running controller; sync before any edge detection
   acrb_sync #(.W(3), .INIT(SER_SYNC_INIT)) u_ser_sync ( // [R24]
      .clk_i  (REF_CLK_I),
      .srst_i (SRST_I),
      .d_i    ({SERIAL_SELECT_N_I, SERIAL_CLK_I, SERIAL_PORT_INPUT_I}),
      .q_o    (ser_s)
   );

   wire        sen_n_s    = ser_s[2];
   wire        sclk_s     = ser_s[1];
   wire        serial_port_input_s    = ser_s[0];
   wire        sclk_fall  = sclk_d & ~sclk_s & ~sen_n_s;         // [R20]
   wire [15:0] next_shift = {shift[14:0], serial_port_input_s};              // [R21]
   wire        commit     = sclk_fall && (bit_cnt == SERIAL_LAST_BIT); // [R20]
   wire        addr_done  = sclk_fall && (bit_cnt == SERIAL_ADDR_LAST_BIT);
   wire [7:0]  wr_addr    = next_shift[15:8];                    // [R21]
   wire [7:0]  wr_data    = next_shift[7:0];
   wire [7:0]  rd_addr    = next_shift[7:0];
   wire        readout    = reg_q[IDX_CTRL][CTRL_READOUT_BIT];
   wire        wr_ctrl    = wr_addr == REG_ADDR[IDX_CTRL];
   wire        wr_allow   = commit && (!readout || wr_ctrl);     // [R22]
   wire        soft_rst   = wr_allow && wr_ctrl && wr_data[CTRL_SOFT_RESET_BIT]; // [R1]

   logic [NREG-1:0] wr_hit;
   logic [NREG-1:0] rd_hit;
   logic [7:0]      rd_terms [NREG];
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_dec
         assign wr_hit[gi]   = wr_addr == REG_ADDR[gi];         // [R23]
         assign rd_hit[gi]   = rd_addr == REG_ADDR[gi];
         assign rd_terms[gi] = rd_hit[gi] ? reg_q[gi] : 8'h00;
      end
   endgenerate

   logic [7:0] rd_value;
   always_comb begin
      rd_value = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         rd_value = rd_value | rd_terms[i];                      // [R23]
      end
      if (rd_addr == READBACK_BLOCKED_ADDR) begin
         rd_value = 8'h00;                                       // [R22]
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I || soft_rst) begin
         for (int i = 0; i < NREG; i++) begin
            reg_q[i] <= REG_RESET;                               // [R1] [R17]
         end
      end else if (wr_allow) begin
         for (int i = 0; i < NREG; i++) begin
            if (wr_hit[i]) begin
               reg_q[i] <= wr_data & REG_MASK[i];                // [R18]
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         sclk_d  <= 1'b0;
         bit_cnt <= 4'h0;
         shift   <= 16'h0000;
      end else begin
         sclk_d <= sclk_s;
         if (sen_n_s) begin
            bit_cnt <= 4'h0;                                     // [R20]
         end else if (sclk_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            shift   <= next_shift;
         end
      end
   end

   // readback: address phase loads the word, data phase shifts it MSB first
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         rd_sr     <= 8'h00;
         rd_active <= 1'b0;
      end else if (sen_n_s || !readout) begin
         rd_active <= 1'b0;                                      // [R3]
      end else if (addr_done) begin
         rd_sr     <= rd_value;                                  // [R2]
         rd_active <= 1'b1;
      end else if (sclk_fall) begin
         rd_sr     <= {rd_sr[6:0], 1'b0};
         rd_active <= !commit;
      end
   end

   wire next_pin = readout ? (rd_active & rd_sr[7]) : OVERRANGE_I; // [R2] [R3]

   wire [7:0] gain_reg  = reg_q[IDX_GAIN];
   wire       gain_on   = reg_q[IDX_LATENCY][LATENCY_MODE_BIT] & ~gain_reg[GAIN_BYPASS_BIT]; // [R8]
   wire       swing_on  = reg_q[IDX_PDN][1:0] == SWING_EN_ALL;   // [R5]
   wire [13:0] user_word = {reg_q[IDX_UPAT_HI], reg_q[IDX_UPAT_LO][7:2]};
   wire [2:0] pat_code  = gain_reg[2:0];
   wire       ramp_mode = pat_code == PAT_RAMP;
   wire       ramp_step = (DATA_W >= RAMP_FULL_W) || (ramp_div == RAMP_SLOW_DIV_LAST); // [R11] [R12]

   logic [DATA_W-1:0] next_data;
   always_comb begin
      next_data = SAMPLE_I;
      unique case (acrb_pattern_t'(pat_code))
         PAT_NORMAL:  next_data = SAMPLE_I;                      // [R9]
         PAT_ZEROS:   next_data = '0;                            // [R9]
         PAT_ONES:    next_data = '1;                            // [R9]
         PAT_TOGGLE:  next_data = tgl ? ~ALT_WORD : ALT_WORD;    // [R10]
         PAT_RAMP:    next_data = ramp;                          // [R11]
         PAT_CUSTOM:  next_data = user_word[13 -: DATA_W];       // [R13]
         PAT_UNUSED6: next_data = SAMPLE_I;
         PAT_UNUSED7: next_data = SAMPLE_I;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         tgl      <= 1'b0;
         ramp     <= '0;
         ramp_div <= 2'h0;
      end else begin
         tgl <= ~tgl;                                            // [R10]
         // ramp restarts from zero each time the pattern is selected
         ramp_div <= ramp_mode ? ramp_div + 2'h1 : 2'h0;
         if (!ramp_mode) begin
            ramp <= '0;
         end else if (ramp_step) begin
            ramp <= ramp + 1'b1;                                 // [R11] [R12]
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         OVERRANGE_OR_READBACK_PIN_O    <= 1'b0;
         DATA_O                         <= '0;
         SWING_CODE_O                   <= 6'h00;
         GAIN_CODE_O                    <= 4'h0;
         CLOCK_DRIVER_DOUBLE_STRENGTH_O <= 1'b0;
         DATA_DRIVER_DOUBLE_STRENGTH_O  <= 1'b0;
         PERFORMANCE_TUNE_ONE_O         <= 2'h0;
         PERFORMANCE_TUNE_TWO_O         <= 1'b0;
      end else begin
         OVERRANGE_OR_READBACK_PIN_O    <= next_pin;
         DATA_O                         <= next_data;
         SWING_CODE_O                   <= swing_on ? reg_q[IDX_SWING][7:2] : 6'h00; // [R4] [R5]
         GAIN_CODE_O                    <= gain_on ? gain_reg[7:4] : 4'h0;         // [R7] [R8]
         CLOCK_DRIVER_DOUBLE_STRENGTH_O <= reg_q[IDX_DRIVE][DRIVE_CLK_BIT];        // [R14]
         DATA_DRIVER_DOUBLE_STRENGTH_O  <= reg_q[IDX_DRIVE][DRIVE_DATA_BIT];       // [R15]
         PERFORMANCE_TUNE_ONE_O         <= reg_q[IDX_PERF1][1:0];
         PERFORMANCE_TUNE_TWO_O         <= reg_q[IDX_PERF2][0];
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);

   sequence s_soft_write;
      soft_rst;
   endsequence
   sequence s_all_clear;
      reg_q[IDX_CTRL] == 8'h00 && reg_q[IDX_GAIN] == 8'h00 && reg_q[IDX_PDN] == 8'h00;
   endsequence
   property p_soft_reset;
      s_soft_write |=> s_all_clear ##1 (OVERRANGE_OR_READBACK_PIN_O == $past(OVERRANGE_I));
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register set"); // [R1]

   property p_pin_overrange;
      !readout |=> OVERRANGE_OR_READBACK_PIN_O == $past(OVERRANGE_I);
   endproperty
   a_pin_overrange: assert property (p_pin_overrange) else $error("pin not following over-range"); // [R3]

   property p_readback_first;
      readout && addr_done |=> ##1 OVERRANGE_OR_READBACK_PIN_O == $past(rd_value[7], 2);
   endproperty
   a_readback_first: assert property (p_readback_first) else $error("readback MSB wrong"); // [R2]

   property p_swing_gate;
      !swing_on |=> SWING_CODE_O == 6'h00;
   endproperty
   a_swing_gate: assert property (p_swing_gate) else $error("swing code leaked while disabled"); // [R5]

   property p_gain;
      ##1 GAIN_CODE_O == ($past(gain_on) ? $past(gain_reg[7:4]) : 4'h0);
   endproperty
   a_gain: assert property (p_gain) else $error("gain code wrong"); // [R7] [R8]

   sequence s_toggle_held;
      pat_code == PAT_TOGGLE ##1 pat_code == PAT_TOGGLE;
   endsequence
   property p_toggle;
      s_toggle_held |=> DATA_O == ~$past(DATA_O)
         && (DATA_O == ALT_WORD || DATA_O == ~ALT_WORD);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle pattern did not alternate"); // [R10]

   property p_fixed_pat;
      pat_code == PAT_ZEROS |=> DATA_O == '0;
   endproperty
   a_fixed_pat: assert property (p_fixed_pat) else $error("zero pattern wrong"); // [R9]

   property p_ones_pat;
      pat_code == PAT_ONES |=> DATA_O == '1;
   endproperty
   a_ones_pat: assert property (p_ones_pat) else $error("ones pattern wrong"); // [R9]

   property p_ramp;
      ramp_mode && ramp_step && ramp != RAMP_MAX |=> ramp == $past(ramp) + 1'b1 || !ramp_mode;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp did not step"); // [R11] [R12]

   // only the narrow variant has cycles between steps
   property p_ramp_hold;
      ramp_mode && !ramp_step |=> $stable(ramp);
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("ramp stepped between divider ends"); // [R12]

   property p_custom;
      pat_code == PAT_CUSTOM |=> DATA_O == $past(user_word[13 -: DATA_W]);
   endproperty
   a_custom: assert property (p_custom) else $error("custom pattern wrong"); // [R13]

   property p_drive;
      ##1 CLOCK_DRIVER_DOUBLE_STRENGTH_O == $past(reg_q[IDX_DRIVE][DRIVE_CLK_BIT])
         && DATA_DRIVER_DOUBLE_STRENGTH_O == $past(reg_q[IDX_DRIVE][DRIVE_DATA_BIT]);
   endproperty
   a_drive: assert property (p_drive) else $error("driver strength mismatch"); // [R14] [R15]

   property p_write_gain;
      wr_allow && wr_hit[IDX_GAIN] && !soft_rst |=> reg_q[IDX_GAIN] == $past(wr_data);
   endproperty
   a_write_gain: assert property (p_write_gain) else $error("write did not update all fields"); // [R18]

   property p_readout_lock;
      readout && commit && !wr_ctrl |=> $stable(reg_q[IDX_GAIN]) && $stable(reg_q[IDX_SWING]);
   endproperty
   a_readout_lock: assert property (p_readout_lock) else $error("write taken in readout mode"); // [R22]

   property p_unmapped;
      readout && addr_done && rd_hit == '0 |=> rd_sr == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [R23]

   property p_idle_count;
      sen_n_s |=> bit_cnt == 4'h0;
   endproperty
   a_idle_count: assert property (p_idle_count) else $error("bit counter not cleared"); // [R20]
endmodule

// *** design/acrb_sync.sv ***
`timescale 1ns/1ps
module acrb_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta <= INIT;
         q_o  <= INIT;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// *** tb/acrb_ctl_model.sv ***
`timescale 1ns/1ps
module acrb_ctl_model #(
   parameter int PHASE = 5
) (
   input  wire logic clk_i,
   input  wire logic sdout_i,
   output logic      sel_n_o,
   output logic      sclk_o,
   output logic      serial_port_input_o
);
   initial begin
      sel_n_o = 1'b1;
      sclk_o  = 1'b0;
      serial_port_input_o = 1'b0;
   end

   // one 16-bit word per select pulse; readback bits taken just before falls 9..16
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] w;
      w = {a, d};
      q = 8'h00;
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk_i);
         serial_port_input_o <= w[i];
         sclk_o  <= 1'b1;
         repeat (PHASE) @(posedge clk_i);
         if (i < 8) q[i] = sdout_i;
         sclk_o <= 1'b0;
         repeat (PHASE) @(posedge clk_i);
      end
      sel_n_o <= 1'b1;
      // released line must not keep showing the last bit
      serial_port_input_o <= ~w[0];
   endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import acrb_pkg::*;
   logic        ref_clk   = 1'b0;
   logic        srst      = 1'b1;
   logic        overrange = 1'b0;
   logic [13:0] sample    = 14'h0000;
   wire         sel_n;
   wire         sclk;
   wire         serial_port_input;
   wire         pin;
   wire  [13:0] data;
   wire  [5:0]  swing;
   wire  [3:0]  gain;
   wire         clk_dbl;
   wire         dat_dbl;
   wire  [1:0]  perf1;
   wire         perf2;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   logic [7:0]  q;
   logic [13:0] d0;
   logic [13:0] d1;
   logic [11:0] d2;
   wire  [11:0] data12;

   always #20 ref_clk = ~ref_clk;

   acrb_regbank #(.DATA_W(14)) dut (
      .REF_CLK_I(ref_clk), .SRST_I(srst), .SERIAL_SELECT_N_I(sel_n), .SERIAL_CLK_I(sclk),
      .SERIAL_PORT_INPUT_I(serial_port_input), .OVERRANGE_I(overrange), .SAMPLE_I(sample),
      .OVERRANGE_OR_READBACK_PIN_O(pin), .DATA_O(data), .SWING_CODE_O(swing), .GAIN_CODE_O(gain),
      .CLOCK_DRIVER_DOUBLE_STRENGTH_O(clk_dbl), .DATA_DRIVER_DOUBLE_STRENGTH_O(dat_dbl),
      .PERFORMANCE_TUNE_ONE_O(perf1), .PERFORMANCE_TUNE_TWO_O(perf2));

   acrb_ctl_model ctl (.clk_i(ref_clk), .sdout_i(pin), .sel_n_o(sel_n), .sclk_o(sclk), .serial_port_input_o(serial_port_input));

   // 12-bit variant shares the serial lines; only its data path is judged
   acrb_regbank #(.DATA_W(12)) dut_narrow (
      .REF_CLK_I(ref_clk), .SRST_I(srst), .SERIAL_SELECT_N_I(sel_n), .SERIAL_CLK_I(sclk),
      .SERIAL_PORT_INPUT_I(serial_port_input), .OVERRANGE_I(overrange), .SAMPLE_I(sample[13:2]),
      .OVERRANGE_OR_READBACK_PIN_O(), .DATA_O(data12), .SWING_CODE_O(), .GAIN_CODE_O(),
      .CLOCK_DRIVER_DOUBLE_STRENGTH_O(), .DATA_DRIVER_DOUBLE_STRENGTH_O(),
      .PERFORMANCE_TUNE_ONE_O(), .PERFORMANCE_TUNE_TWO_O());

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // sync plus commit latency is a handful of cycles; 8 leaves margin
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ctl.xfer(a, d, q);
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic t_reset;
      chk({swing, gain, clk_dbl, dat_dbl, perf1, perf2}, 16'h0000);
      chk(data, 16'h0000);
   endtask

   task automatic t_drive;
      wr(8'h26, 8'h02);
      chk({clk_dbl, dat_dbl}, 16'h0002);
      wr(8'h26, 8'h01);
      chk({clk_dbl, dat_dbl}, 16'h0001);
      wr(8'h26, 8'h03);
      chk({clk_dbl, dat_dbl}, 16'h0003);
      wr(8'h03, 8'h03);
      wr(8'h4A, 8'h01);
      chk({perf1, perf2}, 16'h0007);
   endtask

   task automatic t_swing;
      wr(8'h01, 8'h6C);
      chk(swing, 16'h0000);
      wr(8'h43, 8'h03);
      chk(swing, 16'h001B);
      wr(8'h01, 8'hF8);
      chk(swing, 16'h003E);
   endtask

   task automatic t_gain;
      wr(8'h25, 8'hC0);
      chk(gain, 16'h0000);
      wr(8'h42, 8'h08);
      chk(gain, 16'h000C);
      wr(8'h25, 8'hC8);
      chk(gain, 16'h0000);
      wr(8'h25, 8'h10);
      chk(gain, 16'h0001);
   endtask

   task automatic t_pattern;
      acrb_pattern_t tbl [5];
      tbl = '{PAT_NORMAL, PAT_ZEROS, PAT_ONES, PAT_UNUSED6, PAT_UNUSED7};
      foreach (tbl[i]) begin
         wr(8'h25, {5'h00, tbl[i]});
         chk(data, (tbl[i] == PAT_ZEROS) ? 16'h0000 : (tbl[i] == PAT_ONES) ? 16'h3FFF : 16'h1234);
      end
      wr(8'h25, 8'h03);
      d0 = data;
      @(negedge ref_clk);
      d1 = data;
      chk(d1, {2'b00, ~d0});
      chk((d0 === 14'h1555) || (d0 === 14'h2AAA), 16'h0001);
      wr(8'h25, 8'h04);
      d0 = data;
      d2 = data12;
      @(negedge ref_clk);
      d1 = data;
      chk(d1, d0 + 14'h0001);
      repeat (3) @(negedge ref_clk);
      chk(data12, {4'h0, d2 + 12'h001});
      wr(8'h3F, 8'hA5);
      wr(8'h40, 8'hC4);
      wr(8'h25, 8'h05);
      chk(data, 16'h2971);
      chk(data12, 16'h0A5C);
   endtask

   task automatic t_readback;
      @(posedge ref_clk) overrange <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(pin, 16'h0001);
      wr(8'h00, 8'h01);
      chk(pin, 16'h0000);
      wr(8'h26, 8'h00);
      ctl.xfer(8'h26, 8'h00, q);
      chk(q, 16'h0003);
      ctl.xfer(8'h25, 8'h00, q);
      chk(q, 16'h0005);
      // readout bit written again so the next read still runs in readout mode
      ctl.xfer(8'h00, 8'h01, q);
      chk(q, 16'h0000);
      ctl.xfer(8'h02, 8'h00, q);
      chk(q, 16'h0000);
      wr(8'h00, 8'h00);
      chk(pin, 16'h0001);
      @(posedge ref_clk) overrange <= 1'b0;
   endtask

   task automatic t_soft_reset;
      wr(8'h00, 8'h02);
      chk({swing, gain, clk_dbl, dat_dbl, perf1, perf2}, 16'h0000);
      chk(data, 16'h1234);
   endtask

   task automatic tally_and_finish;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (4) @(negedge ref_clk);
      t_reset();
      @(posedge ref_clk) sample <= 14'h1234;
      t_drive();
      t_swing();
      t_gain();
      t_pattern();
      t_readback();
      t_soft_reset();
      tally_and_finish();
   end
endmodule
